// ### tb/scd_config_decoder_sva.sv
`timescale 1ns/1ps
// port-level checks of the decoder
module scd_config_decoder_sva #(
    parameter int PHASE_W = 8,
    parameter logic [3:0] DEF_SWALLOW = 4'h0,
    parameter logic [8:0] DEF_PROG = 9'h001,
    parameter logic [8:0] DEF_REF = 9'h002
) (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_LATCH_ENABLE,
    input wire logic I_DEFAULT_SELECT,
    input wire logic I_LOCK_START,
    input wire logic [PHASE_W-1:0] I_PHASE_DIFF,
    input wire logic [1:0] O_BANDWIDTH_DURATION,
    input wire logic [1:0] O_PHASE_CRITERION,
    input wire logic O_BANDWIDTH_ENABLE,
    input wire logic [1:0] O_OSC_DYNAMIC_CURRENT,
    input wire logic O_BW_CTRL_ACTIVE,
    input wire logic [3:0] O_IF_SWALLOW,
    input wire logic [8:0] O_IF_PROG,
    input wire logic [8:0] O_IF_REF,
    input wire logic [12:0] O_IF_DIV_RATIO,
    input wire logic O_TEST_ACTIVE
);
    logic le_ff;
    logic [3:0] lat_age_ff;
    logic [11:0] run_cnt_ff;
    // age since last latch rise, saturating so old rises stay old
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            le_ff <= 1'b0;
            lat_age_ff <= 4'hF;
        end else begin
            le_ff <= I_LATCH_ENABLE;
            lat_age_ff <= (I_LATCH_ENABLE && !le_ff) ? 4'h0 : lat_age_ff + {3'h0, lat_age_ff != 4'hF};
        end
    end
    // cycles the controller has been running
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST)
            run_cnt_ff <= 12'h000;
        else
            run_cnt_ff <= O_BW_CTRL_ACTIVE ? run_cnt_ff + 12'h001 : 12'h000;
    end
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SYS_RST);
    a_ratio_match: assert property (
        $past(O_IF_PROG, 2) == O_IF_PROG && $past(O_IF_SWALLOW, 2) == O_IF_SWALLOW
        |-> O_IF_DIV_RATIO == {O_IF_PROG, 4'h0} + {9'h000, O_IF_SWALLOW}) else $error("ratio wrong");
    a_defsel_counts: assert property (
        I_DEFAULT_SELECT |=> O_IF_PROG == DEF_PROG && O_IF_SWALLOW == DEF_SWALLOW && O_IF_REF == DEF_REF)
        else $error("default counts not applied");
    a_test_masked: assert property (
        I_DEFAULT_SELECT |=> !O_TEST_ACTIVE) else $error("test word active under default select");
    a_fields_latched: assert property (
        !$stable({O_BANDWIDTH_DURATION, O_PHASE_CRITERION, O_BANDWIDTH_ENABLE, O_OSC_DYNAMIC_CURRENT})
        |-> lat_age_ff <= 4'h6) else $error("field changed without latch");
    a_ctrl_start: assert property (
        I_LOCK_START && O_BANDWIDTH_ENABLE && !O_BW_CTRL_ACTIVE |=> O_BW_CTRL_ACTIVE)
        else $error("controller did not start");
    a_ctrl_gated: assert property (
        !O_BANDWIDTH_ENABLE ##1 !O_BANDWIDTH_ENABLE |=> !O_BW_CTRL_ACTIVE) else $error("controller runs disabled");
    a_phase_stop: assert property (
        O_BW_CTRL_ACTIVE && !I_LOCK_START && I_PHASE_DIFF <= ({PHASE_W{1'b1}} >> O_PHASE_CRITERION)
        |-> ##[1:2] !O_BW_CTRL_ACTIVE) else $error("controller ignored phase");
    a_run_bound: assert property (
        run_cnt_ff <= ({10'h000, O_BANDWIDTH_DURATION} + 12'h001) * 12'd800 + 12'd4)
        else $error("controller ran too long");
endmodule

// ### tb/scd_host_model.sv
`timescale 1ns/1ps
// host end of the three-wire link; clock and latch stand low between frames
module scd_host_model (
    input wire logic i_clk,
    output logic o_ser_clk,
    output logic o_ser_data,
    output logic o_latch_enable
);
    initial begin
        o_ser_clk = 1'b0;
        o_ser_data = 1'b0;
        o_latch_enable = 1'b0;
    end
    // msb first, clock one cycle high and one low per bit
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge i_clk) #1;
            o_ser_data = w[i];
            o_ser_clk = 1'b1;
            @(posedge i_clk) #1;
            o_ser_clk = 1'b0;
        end
        @(posedge i_clk) #1;
        o_latch_enable = 1'b1;
        o_ser_data = ~o_ser_data; // data is no longer held after the frame
        @(posedge i_clk) #1;
        o_latch_enable = 1'b0;
    endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk, rst, dsel, lock, sclk, sdata, le, en, act, tact;
    logic [7:0] phase;
    logic [1:0] dur, crit, cur;
    logic [3:0] sw;
    logic [8:0] prog, rref;
    logic [12:0] ratio;
    int n_fail = 0;
    int checks_done = 0;
    scd_host_model host_u (.i_clk(clk), .o_ser_clk(sclk), .o_ser_data(sdata), .o_latch_enable(le));
    scd_config_decoder dut_u (.I_REF_CLK(clk), .I_SYS_RST(rst), .I_SER_CLK(sclk), .I_SER_DATA(sdata),
        .I_LATCH_ENABLE(le), .I_DEFAULT_SELECT(dsel), .I_LOCK_START(lock), .I_PHASE_DIFF(phase),
        .O_BANDWIDTH_DURATION(dur), .O_PHASE_CRITERION(crit), .O_BANDWIDTH_ENABLE(en),
        .O_OSC_DYNAMIC_CURRENT(cur), .O_BW_CTRL_ACTIVE(act), .O_IF_SWALLOW(sw), .O_IF_PROG(prog),
        .O_IF_REF(rref), .O_IF_DIV_RATIO(ratio), .O_TEST_ACTIVE(tact));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // word plus settling: outputs move three edges after the latch
    task automatic wr(input logic [23:0] w);
        host_u.send(w);
        tick(6);
    endtask
    task automatic pulse();
        lock = 1'b1;
        tick(1);
        lock = 1'b0;
        tick(1);
    endtask
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is under two thousand cycles
    initial begin
        #100us;
        n_fail++;
        summarize();
    end
    // main sequence
    initial begin
        rst = 1'b1;
        dsel = 1'b0;
        lock = 1'b0;
        phase = 8'h80;
        tick(20);
        rst = 1'b0;
        chk({dur, crit, en, cur, act, tact}, 36'h1C);
        chk({sw, prog, rref, ratio}, {4'h0, 9'h001, 9'h002, 13'h0010});
        for (int i = 0; i < 4; i++) begin
            wr({i[1:0], ~i[1:0], i[0], 14'h2F46, i[1:0], 3'h3});
            chk({dur, crit, en, cur}, {i[1:0], ~i[1:0], i[0], i[1:0]});
        end
        wr({7'h08, 4'hF, 9'h1FF, 4'h7});
        chk({sw, prog, ratio}, {4'hF, 9'h1FF, 13'h1FFF});
        wr({7'h08, 4'h3, 9'h004, 4'h7});
        chk({sw, prog, ratio}, {4'h3, 9'h004, 13'h0043});
        // top of range first, so the low-end write below must really move the count
        wr({10'h0C4, 9'h1FF, 5'h0F});
        chk(rref, 9'h1FF);
        wr({10'h0C4, 9'h002, 5'h0F});
        chk(rref, 9'h002);
        wr({10'h0C4, 9'h1FF, 5'h0F});
        chk({sw, prog, rref}, {4'h3, 9'h004, 9'h1FF});
        // words with no code of this block change nothing
        for (int i = 0; i < 2; i++) begin
            wr(i == 0 ? 24'hFFFFF8 : 24'hFFFFBF);
            chk({sw, prog, rref, dur, crit, en, cur}, {4'h3, 9'h004, 9'h1FF, 7'h67});
        end
        dsel = 1'b1;
        tick(3);
        chk({sw, prog, rref, ratio}, {4'h0, 9'h001, 9'h002, 13'h0010});
        dsel = 1'b0;
        tick(3);
        chk({sw, prog, rref}, {4'h3, 9'h004, 9'h1FF});
        wr({1'b1, 17'h0, 6'h1F});
        chk({tact, rref}, {1'b0, 9'h1FF});
        wr({1'b1, 16'h0, 1'b1, 6'h1F});
        chk(tact, 1'b1);
        dsel = 1'b1;
        tick(3);
        chk(tact, 1'b0);
        dsel = 1'b0;
        // shortest duration, tightest criterion: threshold 1F
        wr({2'h0, 2'h3, 1'b1, 14'h2F46, 2'h3, 3'h3});
        pulse();
        chk(act, 1'b1);
        phase = 8'h1F;
        tick(3);
        chk(act, 1'b0);
        phase = 8'h80;
        pulse();
        tick(650);
        chk(act, 1'b1);
        tick(160);
        chk(act, 1'b0);
        wr({2'h0, 2'h3, 1'b0, 14'h2F46, 2'h3, 3'h3});
        pulse();
        chk(act, 1'b0);
        summarize();
    end
endmodule
bind scd_config_decoder scd_config_decoder_sva #(.PHASE_W(PHASE_W), .DEF_SWALLOW(DEF_SWALLOW),
    .DEF_PROG(DEF_PROG), .DEF_REF(DEF_REF)) sva_u (.I_REF_CLK(I_REF_CLK), .I_SYS_RST(I_SYS_RST),
    .I_LATCH_ENABLE(I_LATCH_ENABLE), .I_DEFAULT_SELECT(I_DEFAULT_SELECT), .I_LOCK_START(I_LOCK_START),
    .I_PHASE_DIFF(I_PHASE_DIFF), .O_BANDWIDTH_DURATION(O_BANDWIDTH_DURATION),
    .O_PHASE_CRITERION(O_PHASE_CRITERION), .O_BANDWIDTH_ENABLE(O_BANDWIDTH_ENABLE),
    .O_OSC_DYNAMIC_CURRENT(O_OSC_DYNAMIC_CURRENT), .O_BW_CTRL_ACTIVE(O_BW_CTRL_ACTIVE),
    .O_IF_SWALLOW(O_IF_SWALLOW), .O_IF_PROG(O_IF_PROG), .O_IF_REF(O_IF_REF),
    .O_IF_DIV_RATIO(O_IF_DIV_RATIO), .O_TEST_ACTIVE(O_TEST_ACTIVE));

// ### verilog/scd_config_decoder.sv
`timescale 1ns/1ps
// Operation
// - words ending in 011 load the loop-bandwidth and oscillator current register
// - duration code 00 gives shortest controller run, 11 longest
// - criterion code 00 allows largest phase offset, 11 smallest
// - controller stops once phase difference is inside the criterion
// - bandwidth enable: 0 disables controller, 1 runs it while locking
// - two-bit oscillator current, 00 minimum, 11 maximum
// - words ending in 0111 load the if n counter register
// - if n counts apply only while default select is 0
// - swallow count is a 4-bit preset, 0 to 15
// - programmable count is a 9-bit preset, host keeps it 1 to 511
// - if ratio is 16 times programmable plus swallow; host keeps swallow smaller
// - reference count is a 9-bit preset, host keeps it 2 to 511
// - words ending in 01111 load reference count, used only when default select is 0
// - words ending in 011111 load the test word, used only when default select is 0
module scd_config_decoder #(
    parameter int PHASE_W = 8,
    parameter logic [3:0] DEF_SWALLOW = 4'h0,
    parameter logic [8:0] DEF_PROG = 9'h001,
    parameter logic [8:0] DEF_REF = 9'h002
) (
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_SER_CLK,
    input wire logic I_SER_DATA,
    input wire logic I_LATCH_ENABLE,
    input wire logic I_DEFAULT_SELECT,
    input wire logic I_LOCK_START,
    input wire logic [PHASE_W-1:0] I_PHASE_DIFF,
    output logic [1:0] O_BANDWIDTH_DURATION,
    output logic [1:0] O_PHASE_CRITERION,
    output logic O_BANDWIDTH_ENABLE,
    output logic [1:0] O_OSC_DYNAMIC_CURRENT,
    output logic O_BW_CTRL_ACTIVE,
    output logic [3:0] O_IF_SWALLOW,
    output logic [8:0] O_IF_PROG,
    output logic [8:0] O_IF_REF,
    output logic [12:0] O_IF_DIV_RATIO,
    output logic O_TEST_ACTIVE
);
    if (PHASE_W < 4 || PHASE_W > 16) begin : g_chk_phase
        $error("PHASE_W must lie within 4 to 16");
    end
    if (DEF_PROG == 9'h000 || DEF_REF < 9'h002) begin : g_chk_def
        $error("default counts out of range");
    end

    localparam logic [15:0] DUR_STEP_TICKS = 16'(scd_pkg::DUR_STEP_US);

    scd_word_if wbus ();

    scd_shifter u_shifter (
        .i_clk(I_REF_CLK),
        .i_rst(I_SYS_RST),
        .i_ser_clk(I_SER_CLK),
        .i_ser_data(I_SER_DATA),
        .i_latch_enable(I_LATCH_ENABLE),
        .wout(wbus)
    );

    logic [1:0] bandwidth_duration_ff;
    logic [1:0] bw_crit_ff;
    logic bandwidth_enable_ff;
    logic [1:0] osc_cur_ff;
    logic [3:0] swallow_ff;
    logic [8:0] prog_ff;
    logic [8:0] ref_ff;
    logic [scd_pkg::TEST_W-1:0] test_ff;
    logic [23:0] w;

    assign w = wbus.word;

    // phase threshold: widest at code 00, halved per step toward 11
    function automatic logic [PHASE_W-1:0] crit_limit(input logic [1:0] code);
        logic [PHASE_W-1:0] full;
        full = '1;
        crit_limit = full >> code;
    endfunction

    // run length in ticks grows with the duration code
    function automatic logic [15:0] dur_ticks(input logic [1:0] code);
        dur_ticks = DUR_STEP_TICKS * (16'h0001 + {14'h0000, code});
    endfunction

    // address decode, longest code wins so shorter codes never alias
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            bandwidth_duration_ff <= scd_pkg::RST_BANDWIDTH_DURATION;
            bw_crit_ff <= scd_pkg::RST_BW_CRIT;
            bandwidth_enable_ff <= scd_pkg::RST_BANDWIDTH_ENABLE;
            osc_cur_ff <= scd_pkg::RST_OSC_CUR;
            swallow_ff <= DEF_SWALLOW;
            prog_ff <= DEF_PROG;
            ref_ff <= DEF_REF;
            test_ff <= scd_pkg::RST_TEST;
        end else if (wbus.word_valid) begin
            if (w[5:0] == scd_pkg::ADDR_TEST) begin
                test_ff <= w[scd_pkg::TEST_LSB +: scd_pkg::TEST_W];
            end else if (w[4:0] == scd_pkg::ADDR_IFR) begin
                ref_ff <= w[scd_pkg::IF_REF_LSB +: 9];
            end else if (w[3:0] == scd_pkg::ADDR_IFN) begin
                swallow_ff <= w[scd_pkg::IF_SWALLOW_LSB +: 4];
                prog_ff <= w[scd_pkg::IF_PROG_LSB +: 9];
            end else if (w[2:0] == scd_pkg::ADDR_BW) begin
                bandwidth_duration_ff <= w[scd_pkg::BANDWIDTH_DURATION_LSB +: 2];
                bw_crit_ff <= w[scd_pkg::BW_CRIT_LSB +: 2];
                bandwidth_enable_ff <= w[scd_pkg::BANDWIDTH_ENABLE_POS];
                osc_cur_ff <= w[scd_pkg::OSC_CUR_LSB +: 2];
            end
        end
    end

    // register fields to the analog side
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_BANDWIDTH_DURATION <= scd_pkg::RST_BANDWIDTH_DURATION;
            O_PHASE_CRITERION <= scd_pkg::RST_BW_CRIT;
            O_BANDWIDTH_ENABLE <= scd_pkg::RST_BANDWIDTH_ENABLE;
            O_OSC_DYNAMIC_CURRENT <= scd_pkg::RST_OSC_CUR;
        end else begin
            O_BANDWIDTH_DURATION <= bandwidth_duration_ff;
            O_PHASE_CRITERION <= bw_crit_ff;
            O_BANDWIDTH_ENABLE <= bandwidth_enable_ff;
            O_OSC_DYNAMIC_CURRENT <= osc_cur_ff;
        end
    end

    // default select high forces built-in counts and hides the test word
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_IF_SWALLOW <= DEF_SWALLOW;
            O_IF_PROG <= DEF_PROG;
            O_IF_REF <= DEF_REF;
            O_IF_DIV_RATIO <= 13'(scd_pkg::IF_PRESCALE) * {4'h0, DEF_PROG} + {9'h000, DEF_SWALLOW};
            O_TEST_ACTIVE <= 1'b0;
        end else if (I_DEFAULT_SELECT) begin
            O_IF_SWALLOW <= DEF_SWALLOW;
            O_IF_PROG <= DEF_PROG;
            O_IF_REF <= DEF_REF;
            O_IF_DIV_RATIO <= 13'(scd_pkg::IF_PRESCALE) * {4'h0, DEF_PROG} + {9'h000, DEF_SWALLOW};
            O_TEST_ACTIVE <= 1'b0;
        end else begin
            O_IF_SWALLOW <= swallow_ff;
            O_IF_PROG <= prog_ff;
            O_IF_REF <= ref_ff;
            // no guard for swallow above programmable: the host owns that range
            O_IF_DIV_RATIO <= 13'(scd_pkg::IF_PRESCALE) * {4'h0, prog_ff} + {9'h000, swallow_ff};
            O_TEST_ACTIVE <= (test_ff != scd_pkg::RST_TEST);
        end
    end

    // microsecond tick enable from the reference clock
    logic [7:0] tick_cnt_ff;
    logic tick_ff;
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            tick_cnt_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff == 8'(scd_pkg::TICK_CYC - 1)) begin
            tick_cnt_ff <= 8'h00;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 8'h01;
            tick_ff <= 1'b0;
        end
    end

    // bandwidth controller: runs during locking until phase settles or time ends
    scd_pkg::scd_bw_state_e bw_state_ff;
    logic [15:0] bw_ticks_ff;
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            bw_state_ff <= scd_pkg::SCD_BW_IDLE;
            bw_ticks_ff <= 16'h0000;
            O_BW_CTRL_ACTIVE <= 1'b0;
        end else begin
            case (bw_state_ff)
                scd_pkg::SCD_BW_IDLE: begin
                    if (I_LOCK_START && bandwidth_enable_ff) begin
                        bw_state_ff <= scd_pkg::SCD_BW_RUN;
                        bw_ticks_ff <= dur_ticks(bandwidth_duration_ff);
                        O_BW_CTRL_ACTIVE <= 1'b1;
                    end
                end
                scd_pkg::SCD_BW_RUN: begin
                    if (!bandwidth_enable_ff || I_PHASE_DIFF <= crit_limit(bw_crit_ff) || bw_ticks_ff == 16'h0000) begin
                        bw_state_ff <= scd_pkg::SCD_BW_IDLE;
                        O_BW_CTRL_ACTIVE <= 1'b0;
                    end else if (tick_ff) begin
                        bw_ticks_ff <= bw_ticks_ff - 16'h0001;
                    end
                end
                default: begin
                    bw_state_ff <= scd_pkg::SCD_BW_IDLE;
                    O_BW_CTRL_ACTIVE <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ### verilog/scd_pkg.sv
package scd_pkg;
    // serial word layout
    localparam int WORD_W = 24;

    // address codes, longest first in the decoder
    localparam logic [5:0] ADDR_TEST = 6'h1F;
    localparam logic [4:0] ADDR_IFR = 5'h0F;
    localparam logic [3:0] ADDR_IFN = 4'h7;
    localparam logic [2:0] ADDR_BW = 3'h3;

    // loop-bandwidth and oscillator current word fields
    localparam int BANDWIDTH_DURATION_LSB = 22;
    localparam int BW_CRIT_LSB = 20;
    localparam int BANDWIDTH_ENABLE_POS = 19;
    localparam int OSC_CUR_LSB = 3;

    // if n counter word fields
    localparam int IF_SWALLOW_LSB = 13;
    localparam int IF_PROG_LSB = 4;

    // if reference divider word field
    localparam int IF_REF_LSB = 5;

    // test word data field
    localparam int TEST_LSB = 6;
    localparam int TEST_W = 18;

    // reset values, the recommended settings
    localparam logic [1:0] RST_BANDWIDTH_DURATION = 2'h0;
    localparam logic [1:0] RST_BW_CRIT = 2'h0;
    localparam logic RST_BANDWIDTH_ENABLE = 1'b1;
    localparam logic [1:0] RST_OSC_CUR = 2'h3;
    localparam logic [17:0] RST_TEST = 18'h20000;

    // multiplier of the programmable count in the if divide ratio
    localparam int IF_PRESCALE = 16;

    // controller timing: one tick per microsecond at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    localparam int DUR_STEP_US = 8;

    typedef enum logic {
        SCD_BW_IDLE,
        SCD_BW_RUN
    } scd_bw_state_e;
endpackage

// ### verilog/scd_shifter.sv
`timescale 1ns/1ps
// shifts the three-wire stream in msb first and hands over the word on latch rise
module scd_shifter (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ser_clk,
    input wire logic i_ser_data,
    input wire logic i_latch_enable,
    scd_word_if.src wout
);
    logic ser_clk_d_ff;
    logic latch_d_ff;
    logic [scd_pkg::WORD_W-1:0] shift_ff;
    logic [scd_pkg::WORD_W-1:0] word_ff;
    logic valid_ff;

    // edge history; pins are already synchronous to the clock
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ser_clk_d_ff <= 1'b0;
            latch_d_ff <= 1'b0;
        end else begin
            ser_clk_d_ff <= i_ser_clk;
            latch_d_ff <= i_latch_enable;
        end
    end

    // shift on each rising serial clock, newest bit into the lsb
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            shift_ff <= '0;
        end else if (i_ser_clk && !ser_clk_d_ff) begin
            shift_ff <= {shift_ff[scd_pkg::WORD_W-2:0], i_ser_data};
        end
    end

    // capture on latch rise; the last 24 bits shifted form the word
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            word_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= i_latch_enable && !latch_d_ff;
            if (i_latch_enable && !latch_d_ff) begin
                word_ff <= shift_ff;
            end
        end
    end

    assign wout.word = word_ff;
    assign wout.word_valid = valid_ff;
endmodule

// ### verilog/scd_word_if.sv
`timescale 1ns/1ps
// carries one received serial word from the shifter to the decoder
interface scd_word_if;
    logic [scd_pkg::WORD_W-1:0] word;
    logic word_valid;

    modport src (output word, output word_valid);
    modport dst (input word, input word_valid);
endinterface
